// *** hw/pwr_pkg.sv ***
package pwr_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] CLK_CTRL_OFS = 8'h00;
  localparam logic [7:0] DOG_PERIOD_OFS = 8'h04;
  localparam logic [7:0] PA_WAKE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h14;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h18;

  // Field positions.
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  localparam int PWRDN_BIT = 0;
  localparam int TO_BIT = 1;
  localparam int SLEEPING_BIT = 2;
  localparam int EV_HALT_BIT = 0;
  localparam int EV_WAKE_BIT = 1;
  localparam int EV_DOG_BIT = 2;

  // Reset values.
  localparam logic [1:0] CLK_CTRL_RST = 2'h0;
  localparam logic [2:0] DOG_PERIOD_RST = 3'h3;
  localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;

  // Watchdog divide exponents per period-select code.
  localparam int DOG_EXP_0 = 8;
  localparam int DOG_EXP_1 = 10;
  localparam int DOG_EXP_2 = 12;
  localparam int DOG_EXP_3 = 14;
  localparam int DOG_EXP_4 = 15;
  localparam int DOG_EXP_5 = 16;
  localparam int DOG_EXP_6 = 17;
  localparam int DOG_EXP_7 = 18;
  localparam int DOG_CNT_W = 18;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_SLEEP = 5'b00010,
    ST_IDLE_SLOW = 5'b00100,
    ST_IDLE_BOTH = 5'b01000,
    ST_IDLE_FAST = 5'b10000
  } pwr_state_t;

  typedef struct packed {
    logic halt_exec;
    logic clear_dog_exec;
    logic power_up;
  } cpu_cmd_t;

  typedef struct packed {
    logic core_clk_en;
    logic fast_clk_en;
    logic slow_clk_en;
    logic cpu_stalled;
    logic resume_next;
    logic take_vector;
    logic reset_pc_sp;
  } pwr_ctl_t;

endpackage : pwr_pkg

// *** hw/power_down_wakeup_control.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Halt with both keep bits 0 enters sleep; only watchdog runs.
// - Halt with fast keep 0, slow keep 1 stops fast clock, keeps slow.
// - Halt with both keep bits 1 halts core, both clocks keep running.
// - Halt with fast keep 1, slow keep 0 keeps fast clock, stops slow.
// - Every power-down mode stops the core and freezes memory, registers, ports.
// - Halt sets the power-down flag and clears the timeout flag.
// - Halt clears the watchdog counter, which keeps counting afterwards.
// - Wake on enabled port A falling edge, interrupt request, or watchdog overflow.
// - Power-down flag clears only on power-up or clear-watchdog instruction.
// - Watchdog overflow in power-down sets timeout, resets only PC and SP.
// - Each port A pin has a wake enable; wake resumes after halt.
// - Disabled interrupt or full stack wake resumes after halt, request stays pending.
// - Enabled interrupt with stack room wakes into normal vectoring.
// - An interrupt already pending at halt cannot wake the device.
// - Watchdog counts low-speed internal oscillator ticks, about 32kHz.
// - Watchdog divides its source by 2^8 up to 2^18 via three-bit select.
// - Select codes 000..111 give 2^8,10,12,14,15,16,17,18.
// - Fast keep bit at bit 1, slow keep bit at bit 0, 1 enables.
module power_down_wakeup_control
  import pwr_pkg::*;
#(
  parameter int PA_WIDTH = 8,
  parameter int IRQ_WIDTH = 8
)
(
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RESETN,
  // AXI4-Lite slave.
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Core side, same clock.
  input wire pwr_pkg::cpu_cmd_t CPU_CMD,
  input wire logic [IRQ_WIDTH-1:0] IRQ_REQ,
  input wire logic [IRQ_WIDTH-1:0] IRQ_EN,
  input wire logic STACK_FULL,
  output pwr_pkg::pwr_ctl_t PWR_CTL,
  output logic [IRQ_WIDTH-1:0] IRQ_PENDING,
  // Asynchronous inputs.
  input wire logic [PA_WIDTH-1:0] PORT_A_PIN,
  input wire logic SLOW_OSC_TICK,
  input wire logic FAST_OSC_STABLE,
  // Status and interrupt.
  output logic POWER_DOWN_FLAG,
  output logic WATCHDOG_TIMEOUT_FLAG,
  output logic IRQ
);

  initial
  begin
    if (PA_WIDTH < 1 || PA_WIDTH > 16 || IRQ_WIDTH < 1 || IRQ_WIDTH > 16)
    begin
      $error("power_down_wakeup_control: widths must be 1..16");
    end
  end

  // Synchronisers for pins and oscillator-domain levels.
  logic [PA_WIDTH-1:0] pa_s1_ff, pa_s2_ff, pa_s3_ff;
  logic [2:0] tick_ff;
  logic [1:0] stable_ff;
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pa_s1_ff <= '1;
      pa_s2_ff <= '1;
      pa_s3_ff <= '1;
      tick_ff <= 3'h0;
      stable_ff <= 2'h0;
    end
    else
    begin
      pa_s1_ff <= PORT_A_PIN;
      pa_s2_ff <= pa_s1_ff;
      pa_s3_ff <= pa_s2_ff;
      tick_ff <= {tick_ff[1:0], SLOW_OSC_TICK};
      stable_ff <= {stable_ff[0], FAST_OSC_STABLE};
    end
  end

  wire slow_tick = tick_ff[1] & ~tick_ff[2];
  wire fast_stable = stable_ff[1];

  // Registers.
  logic [1:0] clk_ctrl_ff;
  logic [2:0] dog_sel_ff;
  logic [PA_WIDTH-1:0] pa_wake_ff;
  logic [2:0] irq_stat_ff, irq_en_ff;
  logic pwrdn_ff, to_ff;
  pwr_state_t state_ff, nxt_state;
  logic [DOG_CNT_W-1:0] dog_cnt_ff;
  logic [IRQ_WIDTH-1:0] masked_ff, pend_ff;
  logic fast_wait_ff;

  wire sleeping = (state_ff != ST_RUN);
  wire halt = CPU_CMD.halt_exec & ~sleeping;

  // Halt mode choice from the two keep bits.
  wire fast_keep = clk_ctrl_ff[FAST_KEEP_BIT];
  wire slow_keep = clk_ctrl_ff[SLOW_KEEP_BIT];
  wire pwr_state_t halt_mode =
    (!fast_keep && !slow_keep) ? ST_SLEEP :
    (!fast_keep && slow_keep) ? ST_IDLE_SLOW :
    (fast_keep && slow_keep) ? ST_IDLE_BOTH :
    ST_IDLE_FAST;

  // Watchdog overflow at the selected division ratio.
  wire [4:0] dog_exp =
    (dog_sel_ff == 3'h0) ? 5'(DOG_EXP_0) :
    (dog_sel_ff == 3'h1) ? 5'(DOG_EXP_1) :
    (dog_sel_ff == 3'h2) ? 5'(DOG_EXP_2) :
    (dog_sel_ff == 3'h3) ? 5'(DOG_EXP_3) :
    (dog_sel_ff == 3'h4) ? 5'(DOG_EXP_4) :
    (dog_sel_ff == 3'h5) ? 5'(DOG_EXP_5) :
    (dog_sel_ff == 3'h6) ? 5'(DOG_EXP_6) :
    5'(DOG_EXP_7);
  wire [DOG_CNT_W:0] dog_limit = (DOG_CNT_W+1)'(1) << dog_exp;
  wire dog_ovf = slow_tick &&
    ({1'b0, dog_cnt_ff} == dog_limit - (DOG_CNT_W+1)'(1));

  // Wake sources.
  wire [PA_WIDTH-1:0] pa_fall = pa_s3_ff & ~pa_s2_ff;
  wire pin_wake = |(pa_fall & pa_wake_ff);
  wire [IRQ_WIDTH-1:0] irq_live = IRQ_REQ & ~masked_ff;
  wire irq_wake = |irq_live;
  wire wake = sleeping && (pin_wake || irq_wake || dog_ovf);
  wire irq_vector = irq_wake && |(irq_live & IRQ_EN) && !STACK_FULL;
  wire dog_wake = sleeping && dog_ovf;

  // Fast clock restart wait applies when the mode had stopped it.
  wire fast_was_off = (state_ff == ST_SLEEP) || (state_ff == ST_IDLE_SLOW);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:
      begin
        if (halt)
        begin
          nxt_state = halt_mode;
        end
      end
      ST_SLEEP, ST_IDLE_SLOW, ST_IDLE_BOTH, ST_IDLE_FAST:
      begin
        if (wake)
        begin
          nxt_state = ST_RUN;
        end
      end
      default:
      begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // AXI4-Lite slave: write address and data taken in either order.
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  wire aw_take = S_AXI_AWVALID && !aw_got_ff && !bvalid_ff;
  wire w_take = S_AXI_WVALID && !w_got_ff && !bvalid_ff;
  wire [7:0] wa = aw_got_ff ? awaddr_ff : S_AXI_AWADDR;
  wire [31:0] wd = w_got_ff ? wdata_ff : S_AXI_WDATA;
  wire wr_go = (aw_got_ff || aw_take) && (w_got_ff || w_take);
  wire wr_b0 = wr_go && S_AXI_WSTRB[0];
  wire wr_b1 = wr_go && S_AXI_WSTRB[1];
  wire wr_hit = (wa == CLK_CTRL_OFS) || (wa == DOG_PERIOD_OFS) || (wa == PA_WAKE_OFS) ||
    (wa == IRQ_CLEAR_OFS) || (wa == IRQ_ENABLE_OFS) || (wa == STATUS_OFS) ||
    (wa == IRQ_STATUS_OFS);
  wire wr_clk_ctrl = wr_b0 && (wa == CLK_CTRL_OFS);
  wire wr_dog = wr_b0 && (wa == DOG_PERIOD_OFS);
  wire wr_pa_lo = wr_b0 && (wa == PA_WAKE_OFS);
  wire wr_pa_hi = wr_b1 && (wa == PA_WAKE_OFS);
  wire wr_clr = wr_b0 && (wa == IRQ_CLEAR_OFS);
  wire wr_en = wr_b0 && (wa == IRQ_ENABLE_OFS);
  wire [15:0] pa_wd = {(wr_pa_hi ? wd[15:8] : 8'(16'(pa_wake_ff) >> 8)),
    (wr_pa_lo ? wd[7:0] : 8'(16'(pa_wake_ff)))};
  wire ar_take = S_AXI_ARVALID && !rvalid_ff;
  wire [7:0] ra = S_AXI_ARADDR;
  wire [2:0] status_word = {sleeping, to_ff, pwrdn_ff};
  wire rd_hit = (ra == CLK_CTRL_OFS) || (ra == DOG_PERIOD_OFS) || (ra == PA_WAKE_OFS) ||
    (ra == STATUS_OFS) || (ra == IRQ_STATUS_OFS) || (ra == IRQ_CLEAR_OFS) ||
    (ra == IRQ_ENABLE_OFS);
  wire [31:0] rd_mux =
    (ra == CLK_CTRL_OFS) ? 32'(clk_ctrl_ff) :
    (ra == DOG_PERIOD_OFS) ? 32'(dog_sel_ff) :
    (ra == PA_WAKE_OFS) ? 32'(pa_wake_ff) :
    (ra == STATUS_OFS) ? 32'(status_word) :
    (ra == IRQ_STATUS_OFS) ? 32'(irq_stat_ff) :
    (ra == IRQ_ENABLE_OFS) ? 32'(irq_en_ff) :
    32'h0000_0000;

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else
    begin
      if (aw_take)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (w_take)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
      end
      if (S_AXI_BREADY)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  // Software registers.
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      clk_ctrl_ff <= CLK_CTRL_RST;
      dog_sel_ff <= DOG_PERIOD_RST;
      pa_wake_ff <= '0;
      irq_en_ff <= IRQ_ENABLE_RST;
    end
    else
    begin
      if (wr_clk_ctrl)
      begin
        clk_ctrl_ff <= wd[1:0];
      end
      if (wr_dog)
      begin
        dog_sel_ff <= wd[2:0];
      end
      if (wr_pa_lo || wr_pa_hi)
      begin
        pa_wake_ff <= pa_wd[PA_WIDTH-1:0];
      end
      if (wr_en)
      begin
        irq_en_ff <= wd[2:0];
      end
    end
  end

  // Sticky events: a new event in the clearing cycle survives.
  wire [2:0] ev_now = {dog_wake, wake, halt};
  wire [2:0] clr_mask = wr_clr ? wd[2:0] : 3'h0;

  // Power-down and timeout flags, state, watchdog.
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pwrdn_ff <= 1'b0;
      to_ff <= 1'b0;
      state_ff <= ST_RUN;
      dog_cnt_ff <= '0;
      irq_stat_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      irq_stat_ff <= (irq_stat_ff & ~clr_mask) | ev_now;
      if (CPU_CMD.power_up || CPU_CMD.clear_dog_exec)
      begin
        pwrdn_ff <= 1'b0;
      end
      else if (halt)
      begin
        pwrdn_ff <= 1'b1;
      end
      if (halt)
      begin
        to_ff <= 1'b0;
      end
      else if (dog_ovf)
      begin
        to_ff <= 1'b1;
      end
      if (halt || CPU_CMD.clear_dog_exec || dog_ovf)
      begin
        dog_cnt_ff <= '0;
      end
      else if (slow_tick)
      begin
        dog_cnt_ff <= dog_cnt_ff + 1'b1;
      end
    end
  end

  // Requests pending at halt are masked from waking until they drop.
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      masked_ff <= '0;
      pend_ff <= '0;
      fast_wait_ff <= 1'b0;
    end
    else
    begin
      if (halt)
      begin
        masked_ff <= IRQ_REQ;
      end
      else
      begin
        masked_ff <= masked_ff & IRQ_REQ;
      end
      if (wake && irq_wake && !irq_vector)
      begin
        pend_ff <= pend_ff | irq_live;
      end
      else
      begin
        pend_ff <= pend_ff & IRQ_REQ & ~(IRQ_EN & {IRQ_WIDTH{!STACK_FULL}});
      end
      if (wake && fast_was_off)
      begin
        fast_wait_ff <= 1'b1;
      end
      else if (fast_stable)
      begin
        fast_wait_ff <= 1'b0;
      end
    end
  end

  // Registered outputs toward the core.
  pwr_ctl_t ctl_ff, nxt_ctl;
  always_comb
  begin
    nxt_ctl = '0;
    nxt_ctl.fast_clk_en = (nxt_state == ST_RUN) || (nxt_state == ST_IDLE_BOTH) ||
      (nxt_state == ST_IDLE_FAST);
    nxt_ctl.slow_clk_en = (nxt_state == ST_IDLE_SLOW) || (nxt_state == ST_IDLE_BOTH) ||
      (nxt_state == ST_RUN);
    nxt_ctl.cpu_stalled = (nxt_state != ST_RUN);
    nxt_ctl.core_clk_en = (nxt_state == ST_RUN) &&
      !((wake && fast_was_off) || (fast_wait_ff && !fast_stable));
    nxt_ctl.resume_next = wake && !dog_wake && !irq_vector;
    nxt_ctl.take_vector = wake && !dog_wake && irq_vector;
    nxt_ctl.reset_pc_sp = dog_wake;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctl_ff <= pwr_ctl_t'(7'h70);
      IRQ <= 1'b0;
      IRQ_PENDING <= '0;
    end
    else
    begin
      ctl_ff <= nxt_ctl;
      IRQ <= |(((irq_stat_ff & ~clr_mask) | ev_now) & irq_en_ff);
      IRQ_PENDING <= pend_ff;
    end
  end

  assign PWR_CTL = ctl_ff;
  assign POWER_DOWN_FLAG = pwrdn_ff;
  assign WATCHDOG_TIMEOUT_FLAG = to_ff;
  assign S_AXI_AWREADY = aw_take;
  assign S_AXI_WREADY = w_take;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = ar_take;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

endmodule : power_down_wakeup_control

// *** bench/osc_model.sv ***
`timescale 1ns/1ps
module osc_model
#(
  parameter int HALF_TICK = 2,
  parameter int STABLE_DLY = 6
)
(
  // Clock and enable from the block.
  input wire logic clk,
  input wire logic fast_en,
  // Oscillator outputs.
  output logic slow_tick,
  output logic fast_stable
);
  int n = 0;
  int s = 0;
  initial slow_tick = 1'b0;
  initial fast_stable = 1'b0;
  // The slow oscillator runs free, as the watchdog source must never stop.
  always @(posedge clk)
  begin
    n <= (n == HALF_TICK - 1) ? 0 : n + 1;
    if (n == HALF_TICK - 1)
      slow_tick <= ~slow_tick;
    // A restarted fast oscillator needs time to settle, so stability lags the enable.
    s <= fast_en ? s + 1 : 0;
    fast_stable <= fast_en && s >= STABLE_DLY;
  end
endmodule : osc_model

// *** bench/power_down_wakeup_control_props.sv ***
`timescale 1ns/1ps
module power_down_wakeup_control_props
  import pwr_pkg::*;
(
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RESETN,
  // Core side and status.
  input wire pwr_pkg::cpu_cmd_t CPU_CMD,
  input wire pwr_pkg::pwr_ctl_t PWR_CTL,
  input wire logic FAST_OSC_STABLE,
  input wire logic POWER_DOWN_FLAG,
  input wire logic WATCHDOG_TIMEOUT_FLAG
);
  import pwr_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  logic woke;
  assign woke = PWR_CTL.resume_next | PWR_CTL.take_vector | PWR_CTL.reset_pc_sp;
  sequence halt_taken;
    CPU_CMD.halt_exec && !PWR_CTL.cpu_stalled;
  endsequence
  sequence parked;
    PWR_CTL.cpu_stalled && !PWR_CTL.core_clk_en && POWER_DOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG;
  endsequence
  a_halt_parks: assert property (halt_taken |=> parked)
    else $error("halt did not park the core");
  a_pwrdn_rise: assert property ($rose(POWER_DOWN_FLAG) |-> $past(CPU_CMD.halt_exec))
    else $error("power-down flag set without halt");
  a_pwrdn_fall: assert property ($fell(POWER_DOWN_FLAG) |->
    $past(CPU_CMD.clear_dog_exec) || $past(CPU_CMD.power_up))
    else $error("power-down flag cleared without cause");
  a_one_wake: assert property ($onehot0({PWR_CTL.resume_next, PWR_CTL.take_vector,
    PWR_CTL.reset_pc_sp}))
    else $error("more than one wake action");
  a_wake_exits: assert property (woke |-> !PWR_CTL.cpu_stalled && $past(PWR_CTL.cpu_stalled))
    else $error("wake action outside a stall");
  a_wdt_wake: assert property (PWR_CTL.reset_pc_sp |-> WATCHDOG_TIMEOUT_FLAG &&
    POWER_DOWN_FLAG && $stable(POWER_DOWN_FLAG))
    else $error("watchdog wake flags wrong");
  a_osc_first: assert property ($rose(PWR_CTL.core_clk_en) |-> $past(FAST_OSC_STABLE, 2))
    else $error("core clock before oscillator stable");
  a_stall_gated: assert property (PWR_CTL.cpu_stalled |-> !PWR_CTL.core_clk_en)
    else $error("core clock runs while stalled");
endmodule : power_down_wakeup_control_props

bind power_down_wakeup_control power_down_wakeup_control_props props_inst (
  .CLOCK(CLOCK),
  .RESETN(RESETN),
  .CPU_CMD(CPU_CMD),
  .PWR_CTL(PWR_CTL),
  .FAST_OSC_STABLE(FAST_OSC_STABLE),
  .POWER_DOWN_FLAG(POWER_DOWN_FLAG),
  .WATCHDOG_TIMEOUT_FLAG(WATCHDOG_TIMEOUT_FLAG)
);

// *** bench/power_down_wakeup_control_tb.sv ***
`timescale 1ns/1ps
module power_down_wakeup_control_tb;
  import pwr_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, pwrdn, to, tick, stable;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  cpu_cmd_t cmd = '0;
  pwr_ctl_t ctl;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_en = 8'h00;
  logic [7:0] pend;
  logic [7:0] pins = 8'hff;
  logic stack_full = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int m_pwrdn = 0;
  int m_to = 0;
  int waited;
  int p;
  always #10 clock = ~clock;
  power_down_wakeup_control power_down_wakeup_control_inst (
    .CLOCK(clock), .RESETN(resetn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
    .CPU_CMD(cmd), .IRQ_REQ(irq_req), .IRQ_EN(irq_en), .STACK_FULL(stack_full),
    .PWR_CTL(ctl), .IRQ_PENDING(pend), .PORT_A_PIN(pins), .SLOW_OSC_TICK(tick),
    .FAST_OSC_STABLE(stable), .POWER_DOWN_FLAG(pwrdn), .WATCHDOG_TIMEOUT_FLAG(to), .IRQ(irq));
  osc_model osc_model_inst (.clk(clock), .fast_en(ctl.fast_clk_en), .slow_tick(tick),
    .fast_stable(stable));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
      error_cnt++;
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clock); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (!bvalid) @(posedge clock);
    chk(bresp, er);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock);
    chk(rresp, er);
    if (er == RESP_OKAY)
      chk(rdata, e);
  endtask : rchk

  // Model of the flags: halt sets power-down and clears timeout, clear-watchdog clears power-down.
  task automatic op(input cpu_cmd_t c);
    cmd <= c;
    @(posedge clock);
    cmd <= '0;
    m_pwrdn = c.halt_exec;
    if (c.halt_exec)
      m_to = 0;
    @(posedge clock);
    chk({pwrdn, to}, {m_pwrdn[0], m_to[0]});
  endtask : op

  task automatic wake(input logic [2:0] e, input int n);
    waited = 0;
    while (ctl[2:0] === 3'b000 && waited < n)
    begin
      @(posedge clock);
      waited++;
    end
    chk(ctl[2:0], e);
  endtask : wake

  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #(40000 * 20);
    error_cnt++;
    $display("Error at %0t: run timed out", $time);
    report_and_stop();
  end

  initial
  begin
    void'($urandom(21));
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rchk(CLK_CTRL_OFS, 32'h0, RESP_OKAY);
    rchk(DOG_PERIOD_OFS, 32'h3, RESP_OKAY);
    rchk(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'h0, RESP_SLVERR);
    wr(IRQ_ENABLE_OFS, 32'h7, RESP_OKAY);
    for (int m = 0; m < 4; m++)
    begin
      p = $urandom_range(7, 0);
      wr(CLK_CTRL_OFS, m, RESP_OKAY);
      rchk(CLK_CTRL_OFS, m, RESP_OKAY);
      wr(PA_WAKE_OFS, 32'h1 << p, RESP_OKAY);
      op(3'b100);
      chk(ctl[6:3], {1'b0, m[1:0], 1'b1});
      chk(irq, 1'b1);
      rchk(IRQ_STATUS_OFS, 32'h1, RESP_OKAY);
      pins[(p + 1) % 8] <= 1'b0;
      repeat (8) @(posedge clock);
      chk(ctl.cpu_stalled, 1'b1);
      pins[p] <= 1'b0;
      wake(3'b100, 12);
      pins <= 8'hff;
      chk(pwrdn, 1'b1);
      wr(IRQ_CLEAR_OFS, 32'h7, RESP_OKAY);
      @(posedge clock);
      chk(irq, 1'b0);
      op(3'b010);
      repeat (12) @(posedge clock);
    end
    irq_req <= 8'h01;
    op(3'b100);
    repeat (8) @(posedge clock);
    chk(ctl.cpu_stalled, 1'b1);
    irq_en <= 8'h02;
    irq_req <= 8'h03;
    wake(3'b010, 10);
    irq_req <= 8'h00;
    for (int c = 0; c < 2; c++)
    begin
      irq_en <= c ? 8'h04 : 8'h00;
      stack_full <= c[0];
      op(3'b100);
      irq_req <= 8'h04;
      wake(3'b100, 10);
      // The pending output is registered once more after the wake pulse.
      @(posedge clock);
      chk(pend[2], 1'b1);
      irq_req <= 8'h00;
      stack_full <= 1'b0;
      repeat (3) @(posedge clock);
      chk(pend, 8'h00);
    end
    wr(CLK_CTRL_OFS, 32'h0, RESP_OKAY);
    wr(IRQ_CLEAR_OFS, 32'h7, RESP_OKAY);
    wr(IRQ_ENABLE_OFS, 32'h0, RESP_OKAY);
    // Codes 0 and 1 keep the run short; each slow tick rises every four cycles.
    for (int c = 0; c < 2; c++)
    begin
      wr(DOG_PERIOD_OFS, c, RESP_OKAY);
      op(3'b100);
      wake(3'b001, 5000);
      m_to = 1;
      chk(waited >= (c ? 4096 : 1024) - 8 && waited <= (c ? 4096 : 1024) + 12, 1'b1);
      chk({pwrdn, to}, {m_pwrdn[0], m_to[0]});
      chk(irq, 1'b0);
      op(3'b010);
      repeat (12) @(posedge clock);
    end
    report_and_stop();
  end
endmodule : power_down_wakeup_control_tb
